// [src/mie_pkg.sv]
// Package: register map, field positions and reset values of the interrupt enable block
package mie_pkg;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_DMA0_EOL = 10;
  localparam int BIT_DMA0_DMF = 9;
  localparam int BIT_DMA0_DDL = 8;
  localparam int BIT_I2C_DONE = 4;
  localparam int BIT_BOARD_MGMT = 2;
  // Implemented bits of both enable mask and status
  localparam logic [31:0] IMPL_MASK = 32'h0000_0714;
  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // Number of event inputs, in the order eol, dmf, ddl, i2c, board
  localparam int NUM_EVENTS = 5;
endpackage

// [src/mie_irq_enable.sv]
// Module interrupt enable mask and status with Avalon-MM slave
// Overview of operation
// RL1: Bit 10 enables DMA0 end-of-list interrupt
// RL2: Bit 9 enables DMA0 memory-filled interrupt
// RL3: Bit 8 enables DMA0 descriptor-loaded interrupt
// RL4: Enable zero blocks, one permits interrupt
// RL5: Bit 4 enables I2C bridge done interrupt
// RL6: Bit 2 enables board management interrupt
// RL7: Status bit 10 set on end-of-list, W1C
// RL8: Irq when flag and enable set; reserved zero
`timescale 1ns/10ps
module mie_irq_enable
  import mie_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [mie_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [mie_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [mie_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic dma0_end_of_list_event,
  input wire logic dma0_memory_filled_event,
  input wire logic dma0_descriptor_loaded_event,
  input wire logic i2c_bridge_op_done_event,
  input wire logic board_mgmt_event,
  output logic irq
);
  import mie_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] enable_mask;
  logic [31:0] status;
  logic [31:0] next_enable_mask;
  logic [31:0] next_status;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_irq;
  logic [31:0] event_vec;
  logic [31:0] wmask;
  logic access_done;
  logic req;

  // ----------------------------------------
  // Bus and register next state
  // ----------------------------------------
  // One wait cycle per access: waitrequest drops for one edge, then the
  // request is answered; keeps readdata and irq straight from flops.
  always_comb begin
    req = avs_read | avs_write;
    access_done = req & ~avs_waitrequest;
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    event_vec = 32'h0000_0000;
    event_vec[BIT_DMA0_EOL] = dma0_end_of_list_event; // [RL7]
    event_vec[BIT_DMA0_DMF] = dma0_memory_filled_event;
    event_vec[BIT_DMA0_DDL] = dma0_descriptor_loaded_event;
    event_vec[BIT_I2C_DONE] = i2c_bridge_op_done_event;
    event_vec[BIT_BOARD_MGMT] = board_mgmt_event;
    next_enable_mask = enable_mask;
    next_status = status;
    next_readdata = avs_readdata;
    next_waitrequest = 1'b1;
    if (req && avs_waitrequest) begin
      next_waitrequest = 1'b0;
      case (avs_address)
        ADDR_ENABLE: next_readdata = enable_mask;
        ADDR_STATUS: next_readdata = status;
        default: next_readdata = UNMAPPED_READ;
      endcase
    end
    if (access_done && avs_write && avs_address == ADDR_ENABLE) begin
      // Reserved bits cannot be written
      next_enable_mask = ((enable_mask & ~wmask) | (avs_writedata & wmask)) & IMPL_MASK; // [RL1] [RL2] [RL3] [RL5] [RL6] [RL8]
    end
    if (access_done && avs_write && avs_address == ADDR_STATUS) begin
      next_status = status & ~(avs_writedata & wmask); // [RL7]
    end
    // Set wins over a simultaneous clear
    next_status = (next_status | event_vec) & IMPL_MASK; // [RL7]
    next_irq = |(next_status & next_enable_mask); // [RL4] [RL8]
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      enable_mask <= ENABLE_RESET;
      status <= STATUS_RESET;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end else begin
      enable_mask <= next_enable_mask;
      status <= next_status;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      irq <= next_irq;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_reserved_zero;
    @(posedge clk_sys) disable iff (rst) ((enable_mask | status) & ~IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [RL8]

  property p_eol_sets;
    @(posedge clk_sys) disable iff (rst) dma0_end_of_list_event |=> status[BIT_DMA0_EOL];
  endproperty
  a_eol_sets: assert property (p_eol_sets) else $error("eol flag not set"); // [RL7]

  property p_irq_follows;
    @(posedge clk_sys) disable iff (rst) ##1 irq == |(status & enable_mask);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch"); // [RL4]

  property p_disabled_quiet;
    @(posedge clk_sys) disable iff (rst) (enable_mask == 32'h0000_0000) ##1 (enable_mask == 32'h0000_0000) |-> !irq;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("irq with all disabled"); // [RL4]

  property p_w1c;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_write && avs_address == ADDR_STATUS && avs_writedata[BIT_DMA0_EOL]
       && avs_byteenable[1] && !dma0_end_of_list_event) |=> !status[BIT_DMA0_EOL];
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed"); // [RL7]

  property p_mask_write;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_write && avs_address == ADDR_ENABLE && avs_byteenable[1])
      |=> enable_mask[BIT_DMA0_EOL] == $past(avs_writedata[BIT_DMA0_EOL]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("eol enable not written"); // [RL1]

  property p_dmf_write;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_write && avs_address == ADDR_ENABLE && avs_byteenable[1])
      |=> enable_mask[BIT_DMA0_DMF] == $past(avs_writedata[BIT_DMA0_DMF]);
  endproperty
  a_dmf_write: assert property (p_dmf_write) else $error("dmf enable not written"); // [RL2]

  property p_ddl_write;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_write && avs_address == ADDR_ENABLE && avs_byteenable[1])
      |=> enable_mask[BIT_DMA0_DDL] == $past(avs_writedata[BIT_DMA0_DDL]);
  endproperty
  a_ddl_write: assert property (p_ddl_write) else $error("ddl enable not written"); // [RL3]

  property p_low_write;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_write && avs_address == ADDR_ENABLE && avs_byteenable[0])
      |=> enable_mask[BIT_I2C_DONE] == $past(avs_writedata[BIT_I2C_DONE])
          && enable_mask[BIT_BOARD_MGMT] == $past(avs_writedata[BIT_BOARD_MGMT]);
  endproperty
  a_low_write: assert property (p_low_write) else $error("low enables not written"); // [RL5] [RL6]

  property p_answer;
    @(posedge clk_sys) disable iff (rst) (req && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer in one cycle");

  property p_wait_one;
    @(posedge clk_sys) disable iff (rst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");

  property p_dmf_sets;
    @(posedge clk_sys) disable iff (rst) dma0_memory_filled_event |=> status[BIT_DMA0_DMF];
  endproperty
  a_dmf_sets: assert property (p_dmf_sets) else $error("dmf flag not set"); // [RL2]

  property p_ddl_sets;
    @(posedge clk_sys) disable iff (rst) dma0_descriptor_loaded_event |=> status[BIT_DMA0_DDL];
  endproperty
  a_ddl_sets: assert property (p_ddl_sets) else $error("ddl flag not set"); // [RL3]

  property p_i2c_sets;
    @(posedge clk_sys) disable iff (rst) i2c_bridge_op_done_event |=> status[BIT_I2C_DONE];
  endproperty
  a_i2c_sets: assert property (p_i2c_sets) else $error("i2c flag not set"); // [RL5]

  property p_board_sets;
    @(posedge clk_sys) disable iff (rst) board_mgmt_event |=> status[BIT_BOARD_MGMT];
  endproperty
  a_board_sets: assert property (p_board_sets) else $error("board flag not set"); // [RL6]

  // A flag may only rise on its own event, never on a bus write
  property p_eol_no_spurious;
    @(posedge clk_sys) disable iff (rst) !dma0_end_of_list_event |=> !$rose(status[BIT_DMA0_EOL]);
  endproperty
  a_eol_no_spurious: assert property (p_eol_no_spurious) else $error("eol flag rose without event"); // [RL7]

  property p_read_enable;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_read && avs_address == ADDR_ENABLE) |-> avs_readdata == $past(enable_mask);
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable read wrong"); // [RL1] [RL2] [RL3] [RL5] [RL6]

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (rst)
      (access_done && avs_read && avs_address != ADDR_ENABLE && avs_address != ADDR_STATUS)
      |-> avs_readdata == UNMAPPED_READ;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [RL8]

  // Enables are software state only; no event may disturb them
  property p_enable_hold;
    @(posedge clk_sys) disable iff (rst)
      !(access_done && avs_write && avs_address == ADDR_ENABLE) |=> $stable(enable_mask);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed without write"); // [RL4]

  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
  c_set_clear: cover property (@(posedge clk_sys) disable iff (rst)
    access_done && avs_write && avs_address == ADDR_STATUS && dma0_end_of_list_event);
  c_read_status: cover property (@(posedge clk_sys) disable iff (rst)
    access_done && avs_read && avs_address == ADDR_STATUS);
  // A pending flag held back by its mask
  c_masked_pending: cover property (@(posedge clk_sys) disable iff (rst)
    (|(status & ~enable_mask)) && !irq);
endmodule

// [tb/mie_irq_enable_tb_top.sv]
// Self-checking testbench for the interrupt enable mask and status block
`timescale 1ns/10ps
module mie_irq_enable_tb_top;
  import mie_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [NUM_EVENTS-1:0] ev = '0;
  logic irq;
  logic [31:0] rdat;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  int bitpos [NUM_EVENTS] = '{BIT_DMA0_EOL, BIT_DMA0_DMF, BIT_DMA0_DDL, BIT_I2C_DONE, BIT_BOARD_MGMT};

  mie_irq_enable i_mie_irq_enable (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .dma0_end_of_list_event(ev[0]),
    .dma0_memory_filled_event(ev[1]),
    .dma0_descriptor_loaded_event(ev[2]),
    .i2c_bridge_op_done_event(ev[3]),
    .board_mgmt_event(ev[4]),
    .irq(irq)
  );
  // ----------------------------------------
  // Clock, timeout and tasks
  // ----------------------------------------
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  // Whole run needs well under 1000 cycles; a hung handshake ends here
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One Avalon-MM access; held until waitrequest is sampled low
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    acc(1'b0, ADDR_ENABLE, 32'h0, 4'hf);
    chk(rdat, ENABLE_RESET);
    acc(1'b0, ADDR_STATUS, 32'h0, 4'hf);
    chk(rdat, STATUS_RESET);
    acc(1'b1, ADDR_ENABLE, 32'hffff_ffff, 4'hf);
    acc(1'b0, ADDR_ENABLE, 32'h0, 4'hf);
    chk(rdat, IMPL_MASK);
    // Only lane 1 cleared, so the low enables must survive
    acc(1'b1, ADDR_ENABLE, 32'h0, 4'h2);
    acc(1'b0, ADDR_ENABLE, 32'h0, 4'hf);
    chk(rdat, 32'h0000_0014);
    acc(1'b1, ADDR_ENABLE, 32'h0, 4'hf);
    acc(1'b1, 8'h10, 32'hffff_ffff, 4'hf);
    acc(1'b0, 8'h10, 32'h0, 4'hf);
    chk(rdat, UNMAPPED_READ);
    // The unmapped write must not alias onto the mask
    acc(1'b0, ADDR_ENABLE, 32'h0, 4'hf);
    chk(rdat, 32'h0000_0000);
    $display("Test registers done");
    for (int i = 0; i < NUM_EVENTS; i++) begin
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev[i] <= 1'b0;
      acc(1'b0, ADDR_STATUS, 32'h0, 4'hf);
      chk(rdat, 32'h1 << bitpos[i]);
      chk(irq, 1'b0);
      // Every enable but the matching one: the flag must stay masked
      acc(1'b1, ADDR_ENABLE, IMPL_MASK & ~(32'h1 << bitpos[i]), 4'hf);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0);
      acc(1'b1, ADDR_ENABLE, 32'h1 << bitpos[i], 4'hf);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b1);
      // Ones on the other byte lanes must leave the flag alone
      acc(1'b1, ADDR_STATUS, 32'hffff_ffff, 4'hf ^ (4'h1 << (bitpos[i] / 8)));
      acc(1'b0, ADDR_STATUS, 32'h0, 4'hf);
      chk(rdat, 32'h1 << bitpos[i]);
      acc(1'b1, ADDR_STATUS, 32'h1 << bitpos[i], 4'hf);
      repeat (2) @(posedge clk_sys);
      chk(irq, 1'b0);
      acc(1'b0, ADDR_STATUS, 32'h0, 4'hf);
      chk(rdat, 32'h0000_0000);
      acc(1'b1, ADDR_ENABLE, 32'h0, 4'hf);
    end
    $display("Test events done");
    // Second reset in mid-run, with enables and flags to lose
    acc(1'b1, ADDR_ENABLE, IMPL_MASK, 4'hf);
    @(posedge clk_sys);
    ev <= '1;
    @(posedge clk_sys);
    ev <= '0;
    repeat (2) @(posedge clk_sys);
    chk(irq, 1'b1);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk(irq, 1'b0);
    acc(1'b0, ADDR_ENABLE, 32'h0, 4'hf);
    chk(rdat, ENABLE_RESET);
    acc(1'b0, ADDR_STATUS, 32'h0, 4'hf);
    chk(rdat, STATUS_RESET);
    $display("Test reset done");
    results();
  end
endmodule
